/* src/tcf_pkg.sv */
// constants for the panel timing controller format configuration block
package tcf_pkg;

  // configuration memory byte addresses
  localparam logic [4:0] TCF_ADDR_MARKER     = 5'h00;
  localparam logic [4:0] TCF_ADDR_FMT_FIRST  = 5'h01;
  localparam logic [4:0] TCF_ADDR_FMT_SECOND = 5'h02;
  localparam logic [4:0] TCF_ADDR_DRIVE      = 5'h03;
  localparam logic [4:0] TCF_ADDR_SUM_LAST   = 5'h1E;
  localparam logic [4:0] TCF_ADDR_CHECKSUM   = 5'h1F;
  localparam int         TCF_MEM_BYTES       = 32;

  // presence pattern held in byte zero
  localparam logic [7:0] TCF_MARKER_VALUE    = 8'hAA;

  // first format word fields
  localparam int TCF_F1_RES_LSB   = 0;
  localparam int TCF_F1_DUAL      = 3;
  localparam int TCF_F1_ZERO      = 4;
  localparam int TCF_F1_VID_INV   = 5;
  localparam int TCF_F1_POL_2LINE = 6;
  localparam int TCF_F1_MOUNT     = 7;

  // second format word fields
  localparam int TCF_F2_OE_POL    = 0;
  localparam int TCF_F2_INIT_LSB  = 1;
  localparam int TCF_F2_VB_INT    = 3;
  localparam int TCF_F2_IN8       = 4;
  localparam int TCF_F2_OUT8      = 5;
  localparam int TCF_F2_DITHER    = 6;
  localparam int TCF_F2_CLK_OPEN  = 7;

  // drive-level word fields
  localparam int TCF_DL_CLKDRV_LSB = 0;
  localparam int TCF_DL_PLL_LOW    = 3;
  localparam int TCF_DL_DPRE_LSB   = 4;
  localparam int TCF_DL_CPRE_LSB   = 6;

  // resolution codes
  localparam logic [2:0] TCF_RES_XGA      = 3'h0;
  localparam logic [2:0] TCF_RES_SXGA     = 3'h1;
  localparam logic [2:0] TCF_RES_SXGA_P   = 3'h2;
  localparam logic [2:0] TCF_RES_UXGA     = 3'h3;
  localparam logic [2:0] TCF_RES_UXGA_FPT = 3'h4;
  localparam logic [2:0] TCF_RES_QXGA     = 3'h6;

  // clock drive code limit (111 is reserved)
  localparam logic [2:0] TCF_CLKDRV_MAX   = 3'h6;

  // pll minimum frequency in tenths of the reference
  localparam logic [5:0] TCF_PLL_MIN_X10_HI = 6'h28; // 4.0x
  localparam logic [5:0] TCF_PLL_MIN_X10_LO = 6'h1C; // 2.8x

  // pre-emphasis step in percent
  localparam logic [6:0] TCF_PREEMPH_STEP = 7'h14; // 20 percent

  // built-in default sets: first format word
  localparam logic [7:0] TCF_F1_DEF0 = 8'hAE;
  localparam logic [7:0] TCF_F1_DEF1 = 8'h8A;
  localparam logic [7:0] TCF_F1_DEF2 = 8'h8B;
  localparam logic [7:0] TCF_F1_DEF3 = 8'h40;
  // second format word
  localparam logic [7:0] TCF_F2_DEF0 = 8'h01;
  localparam logic [7:0] TCF_F2_DEF1 = 8'h01;
  localparam logic [7:0] TCF_F2_DEF2 = 8'h01;
  localparam logic [7:0] TCF_F2_DEF3 = 8'h03;
  // drive-level word
  localparam logic [7:0] TCF_DL_DEF0 = 8'h00;
  localparam logic [7:0] TCF_DL_DEF1 = 8'h00;
  localparam logic [7:0] TCF_DL_DEF2 = 8'h00;
  localparam logic [7:0] TCF_DL_DEF3 = 8'h00;

  // gate output-enable level held before the memory has been read
  localparam logic TCF_OE_POL_RESET = 1'b0;

endpackage

/* src/tcf_pixel_fmt.sv */
// per-colour pixel width conversion, dithering, truncation and inversion
`timescale 1ns/1ns
module tcf_pixel_fmt
  import tcf_pkg::*;
#(
  parameter int COLOURS = 3
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   in_8bit_i,
  input  wire logic                   out_8bit_i,
  input  wire logic                   dither_en_i,
  input  wire logic                   video_invert_i,
  input  wire logic                   pix_valid_i,
  input  wire logic [COLOURS*8-1:0]   pix_data_i,
  output logic                        pix_valid_o,
  output logic      [COLOURS*8-1:0]   pix_data_o
);

  logic [1:0] dither_phase; // rotating dither offset

  // dither phase advances once per accepted pixel
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dither_phase <= 2'h0;
    end else if (pix_valid_i) begin
      dither_phase <= dither_phase + 2'h1;
    end
  end

  // output valid follows input by one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_valid_o <= 1'b0;
    end else begin
      pix_valid_o <= pix_valid_i;
    end
  end

  genvar c;
  generate
    for (c = 0; c < COLOURS; c++) begin : g_colour
      logic [7:0] in_v;
      logic [8:0] dith_sum;
      logic [7:0] next_v;

      assign in_v     = pix_data_i[c*8 +: 8];
      assign dith_sum = {1'b0, in_v} + {7'h00, dither_phase};

      // width conversion, then inversion inside the active width
      always_comb begin
        next_v = in_v;
        if (in_8bit_i && !out_8bit_i) begin
          if (dither_en_i) begin
            next_v = dith_sum[8] ? 8'h3F : {2'h0, dith_sum[7:2]};
          end else begin
            next_v = {2'h0, in_v[7:2]};
          end
        end else if (!in_8bit_i && out_8bit_i) begin
          next_v = {in_v[5:0], in_v[5:4]};
        end else if (!in_8bit_i) begin
          next_v = {2'h0, in_v[5:0]};
        end
        if (video_invert_i) begin
          next_v = out_8bit_i ? ~next_v : {2'h0, ~next_v[5:0]};
        end
      end

      // registered pixel output
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pix_data_o[c*8 +: 8] <= 8'h00;
        end else if (pix_valid_i) begin
          pix_data_o[c*8 +: 8] <= next_v;
        end
      end
    end
  endgenerate

endmodule // tcf_pixel_fmt

/* src/tcf_format_config.sv */
`timescale 1ns/1ns
module tcf_format_config
  import tcf_pkg::*;
#(
  parameter int COLOURS = 3
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // product variant strap choosing the built-in set
  input  wire logic [1:0]           default_set_sel_i,
  // bytes delivered by the memory read sequencer
  input  wire logic                 mem_byte_valid_i,
  input  wire logic [4:0]           mem_byte_addr_i,
  input  wire logic [7:0]           mem_byte_data_i,
  input  wire logic                 mem_read_done_i,
  // clock forwarding
  input  wire logic                 pixel_clock_input_i,
  output logic                      forwarded_clock_output_o,
  // pixel path
  input  wire logic                 pix_valid_i,
  input  wire logic [COLOURS*8-1:0] pix_data_i,
  output logic                      pix_valid_o,
  output logic [COLOURS*8-1:0]      pix_data_o,
  // configuration status
  output logic                      config_done_o,
  output logic                      config_from_mem_o,
  output logic                      marker_error_o,
  output logic                      checksum_error_o,
  output logic [7:0]                format_control_first_o,
  output logic [7:0]                format_control_second_o,
  output logic [7:0]                output_drive_levels_o,
  // decoded first word
  output logic [2:0]                resolution_o,
  output logic                      resolution_valid_o,
  output logic                      dual_port_o,
  output logic                      video_invert_o,
  output logic                      inversion_pattern_select_o,
  output logic                      controller_mount_side_o,
  output logic                      reserved_bit_error_o,
  // decoded second word
  output logic                      gate_oe_level_o,
  output logic [1:0]                gate_init_frames_o,
  output logic                      vblank_internal_o,
  output logic                      input_8bit_o,
  output logic                      output_8bit_o,
  output logic                      dither_en_o,
  output logic                      clock_passthru_o,
  // decoded drive-level word
  output logic [3:0]                clock_drive_half_x_o,
  output logic                      clock_drive_valid_o,
  output logic [5:0]                pll_min_x10_o,
  output logic [6:0]                data_preemph_pct_o,
  output logic [6:0]                clock_preemph_pct_o
);

  typedef enum logic [1:0] {
    TCF_ST_WAIT,
    TCF_ST_LOAD,
    TCF_ST_DONE
  } tcf_state_t;

  tcf_state_t  state;
  logic [1:0]  strap_s2;
  logic [1:0]  strap_s3;
  logic [1:0]  default_sel;
  logic [7:0]  marker_byte;
  logic [7:0]  load_first;
  logic [7:0]  load_second;
  logic [7:0]  load_drive;
  logic [7:0]  stored_sum;
  logic [7:0]  running_sum;
  logic [TCF_MEM_BYTES-1:0] seen;
  logic        use_loaded;
  logic [7:0]  def_first;
  logic [7:0]  def_second;
  logic [7:0]  def_drive;
  logic [7:0]  act_first;
  logic [7:0]  act_second;
  logic [7:0]  act_drive;
  logic        marker_ok;
  logic        sum_ok;
  logic [7:0]  f1_q;
  logic [7:0]  f2_q;
  logic [7:0]  dl_q;

  // three-stage strap synchroniser; first stage feeds only the second
  logic [1:0] strap_s1;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
      strap_s3 <= 2'h0;
    end else begin
      strap_s1 <= default_set_sel_i;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  // strap counts once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      default_sel <= 2'h0;
    end else begin
      if (strap_s2 == strap_s3) begin
        default_sel <= strap_s3;
      end
    end
  end

  // load sequencing: wait for the first byte, collect, then settle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= TCF_ST_WAIT;
    end else begin
      unique case (state)
        TCF_ST_WAIT: begin
          if (mem_read_done_i) begin
            state <= TCF_ST_DONE;
          end else if (mem_byte_valid_i) begin
            state <= TCF_ST_LOAD;
          end
        end
        TCF_ST_LOAD: begin
          if (mem_read_done_i) begin
            state <= TCF_ST_DONE;
          end
        end
        TCF_ST_DONE: begin
          state <= TCF_ST_DONE;
        end
      endcase
    end
  end

  // capture of marker, the three words and the stored checksum
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      marker_byte <= 8'h00;
      load_first  <= 8'h00;
      load_second <= 8'h00;
      load_drive  <= 8'h00;
      stored_sum  <= 8'h00;
    end else if (mem_byte_valid_i && state != TCF_ST_DONE) begin
      unique case (mem_byte_addr_i)
        TCF_ADDR_MARKER:     marker_byte <= mem_byte_data_i;
        TCF_ADDR_FMT_FIRST:  load_first  <= mem_byte_data_i;
        TCF_ADDR_FMT_SECOND: load_second <= mem_byte_data_i;
        TCF_ADDR_DRIVE:      load_drive  <= mem_byte_data_i;
        TCF_ADDR_CHECKSUM:   stored_sum  <= mem_byte_data_i;
        default: ;
      endcase
    end
  end

  // modulo-256 sum over 00h..1Eh and a record of bytes seen
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_sum <= 8'h00;
      seen        <= '0;
    end else if (mem_byte_valid_i && state != TCF_ST_DONE) begin
      seen[mem_byte_addr_i] <= 1'b1;
      if (mem_byte_addr_i <= TCF_ADDR_SUM_LAST) begin
        running_sum <= running_sum + mem_byte_data_i;
      end
    end
  end

  assign marker_ok = (marker_byte == TCF_MARKER_VALUE);
  assign sum_ok    = (running_sum == stored_sum) && (&seen);

  // decision at end of read; a failed check leaves the defaults active
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      use_loaded       <= 1'b0;
      config_done_o    <= 1'b0;
      marker_error_o   <= 1'b0;
      checksum_error_o <= 1'b0;
    end else if (mem_read_done_i && state != TCF_ST_DONE) begin
      config_done_o    <= 1'b1;
      marker_error_o   <= !marker_ok;
      checksum_error_o <= marker_ok && !sum_ok;
      use_loaded       <= marker_ok && sum_ok;
    end
  end

  assign config_from_mem_o = use_loaded;

  // built-in default sets chosen by the product variant
  always_comb begin
    unique case (default_sel)
      2'h0: begin
        def_first  = TCF_F1_DEF0;                         // default_set_zero
        def_second = TCF_F2_DEF0;
        def_drive  = TCF_DL_DEF0;
      end
      2'h1: begin
        def_first  = TCF_F1_DEF1;
        def_second = TCF_F2_DEF1;
        def_drive  = TCF_DL_DEF1;
      end
      2'h2: begin
        def_first  = TCF_F1_DEF2;
        def_second = TCF_F2_DEF2;
        def_drive  = TCF_DL_DEF2;
      end
      2'h3: begin
        def_first  = TCF_F1_DEF3;                         // default_set_three
        def_second = TCF_F2_DEF3;
        def_drive  = TCF_DL_DEF3;
      end
    endcase
  end

  // active words: loaded set only after a valid load
  assign act_first  = use_loaded ? load_first  : def_first;
  assign act_second = use_loaded ? load_second : def_second;
  assign act_drive  = use_loaded ? load_drive  : def_drive;

  // registered copies of the active words
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f1_q <= 8'h00;
      f2_q <= 8'h00;
      dl_q <= 8'h00;
    end else begin
      f1_q <= act_first;
      f2_q <= act_second;
      dl_q <= act_drive;
    end
  end

  assign format_control_first_o  = f1_q;
  assign format_control_second_o = f2_q;
  assign output_drive_levels_o   = dl_q;

  // first word decode
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resolution_o               <= TCF_RES_XGA;
      resolution_valid_o         <= 1'b0;
      dual_port_o                <= 1'b0;
      video_invert_o             <= 1'b0;
      inversion_pattern_select_o <= 1'b0;
      controller_mount_side_o    <= 1'b0;
      reserved_bit_error_o       <= 1'b0;
    end else begin
      resolution_o <= act_first[TCF_F1_RES_LSB +: 3];
      unique case (act_first[TCF_F1_RES_LSB +: 3])
        TCF_RES_XGA, TCF_RES_SXGA, TCF_RES_SXGA_P,
        TCF_RES_UXGA, TCF_RES_UXGA_FPT, TCF_RES_QXGA:
          resolution_valid_o <= 1'b1;
        default:
          resolution_valid_o <= 1'b0;
      endcase
      dual_port_o                <= act_first[TCF_F1_DUAL];
      video_invert_o             <= act_first[TCF_F1_VID_INV];
      inversion_pattern_select_o <= act_first[TCF_F1_POL_2LINE];
      controller_mount_side_o    <= act_first[TCF_F1_MOUNT];
      // flags a programmed image that broke the must-be-zero bit
      reserved_bit_error_o <= use_loaded && act_first[TCF_F1_ZERO];
    end
  end

  // second word decode; oe level waits for the end of the read
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_oe_level_o    <= TCF_OE_POL_RESET;
      gate_init_frames_o <= 2'h0;
      vblank_internal_o  <= 1'b0;
      input_8bit_o       <= 1'b0;
      output_8bit_o      <= 1'b0;
      dither_en_o        <= 1'b0;
      clock_passthru_o   <= 1'b0;
    end else begin
      if (config_done_o) begin
        gate_oe_level_o <= act_second[TCF_F2_OE_POL];
      end
      gate_init_frames_o <= act_second[TCF_F2_INIT_LSB +: 2];
      vblank_internal_o  <= act_second[TCF_F2_VB_INT];
      input_8bit_o       <= act_second[TCF_F2_IN8];
      output_8bit_o      <= act_second[TCF_F2_OUT8];
      dither_en_o        <= act_second[TCF_F2_DITHER];
      clock_passthru_o   <= !act_second[TCF_F2_CLK_OPEN];
    end
  end

  // clock forwarded only while pass-through is selected
  assign forwarded_clock_output_o =
    pixel_clock_input_i & clock_passthru_o;

  // drive-level word decode
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_drive_half_x_o <= 4'h2;
      clock_drive_valid_o  <= 1'b0;
      pll_min_x10_o        <= TCF_PLL_MIN_X10_HI;
      data_preemph_pct_o   <= 7'h00;
      clock_preemph_pct_o  <= 7'h00;
    end else begin
      // 1x is two half steps, each code adds one half step
      clock_drive_half_x_o <=
        {1'b0, act_drive[TCF_DL_CLKDRV_LSB +: 3]} + 4'h2;
      clock_drive_valid_o <=
        act_drive[TCF_DL_CLKDRV_LSB +: 3] <= TCF_CLKDRV_MAX;
      pll_min_x10_o <= act_drive[TCF_DL_PLL_LOW] ?
        TCF_PLL_MIN_X10_LO : TCF_PLL_MIN_X10_HI;
      data_preemph_pct_o <= 7'(act_drive[TCF_DL_DPRE_LSB +: 2]
        * TCF_PREEMPH_STEP);
      clock_preemph_pct_o <= 7'(act_drive[TCF_DL_CPRE_LSB +: 2]
        * TCF_PREEMPH_STEP);
    end
  end

  // pixel formatting under the decoded width, dither and inversion
  tcf_pixel_fmt #(
    .COLOURS (COLOURS)
  ) u_pixel_fmt (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .in_8bit_i      (input_8bit_o),
    .out_8bit_i     (output_8bit_o),
    .dither_en_i    (dither_en_o),
    .video_invert_i (video_invert_o),
    .pix_valid_i    (pix_valid_i),
    .pix_data_i     (pix_data_i),
    .pix_valid_o    (pix_valid_o),
    .pix_data_o     (pix_data_o)
  );

endmodule // tcf_format_config

/* testbench/tcf_format_config_sva.sv */
// assertion checker for the format configuration block
`timescale 1ns/1ns
module tcf_format_config_sva (
  input wire logic       sys_clk_i, rst_n_i, pix_valid_i, pix_valid_o,
  input wire logic       mem_read_done_i, config_done_o, config_from_mem_o,
  input wire logic       marker_error_o, checksum_error_o, gate_oe_level_o,
  input wire logic       resolution_valid_o, clock_passthru_o,
  input wire logic       pixel_clock_input_i, forwarded_clock_output_o,
  input wire logic       clock_drive_valid_o,
  input wire logic [7:0] format_control_first_o, format_control_second_o,
  input wire logic [7:0] output_drive_levels_o,
  input wire logic [2:0] resolution_o,
  input wire logic [3:0] clock_drive_half_x_o,
  input wire logic [5:0] pll_min_x10_o,
  input wire logic [6:0] data_preemph_pct_o, clock_preemph_pct_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // decodes follow the active words; status ties to the memory load
  property p_res;
    $past(rst_n_i) |-> resolution_o == format_control_first_o[2:0] &&
      resolution_valid_o == !(format_control_first_o[2:0] inside {3'h5, 3'h7});
  endproperty
  a_res: assert property (p_res) else $error("resolution wrong");
  property p_oe_hold;
    !config_done_o |-> !gate_oe_level_o;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe early");
  property p_oe_follow;
    config_done_o && $past(config_done_o, 2) |-> {7'h00, gate_oe_level_o}
      == ($past(format_control_second_o) & 8'h01);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("oe wrong");
  property p_pass;
    $past(rst_n_i) |-> clock_passthru_o == !format_control_second_o[7];
  endproperty
  a_pass: assert property (p_pass) else $error("passthru wrong");
  property p_fwd;
    forwarded_clock_output_o == (pixel_clock_input_i && clock_passthru_o);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward wrong");
  property p_drive;
    $past(rst_n_i) |-> clock_drive_half_x_o ==
      {1'b0, output_drive_levels_o[2:0]} + 4'h2 && clock_drive_valid_o ==
      (output_drive_levels_o[2:0] != 3'h7) && pll_min_x10_o ==
      (output_drive_levels_o[3] ? 6'h1C : 6'h28);
  endproperty
  a_drive: assert property (p_drive) else $error("drive wrong");
  property p_pre;
    $past(rst_n_i) |->
      data_preemph_pct_o == 7'(output_drive_levels_o[5:4]) * 7'h14 &&
      clock_preemph_pct_o == 7'(output_drive_levels_o[7:6]) * 7'h14;
  endproperty
  a_pre: assert property (p_pre) else $error("preemph wrong");
  property p_pix;
    pix_valid_i |=> pix_valid_o;
  endproperty
  a_pix: assert property (p_pix) else $error("pixel lost");
  property p_done;
    mem_read_done_i || config_done_o |=> config_done_o;
  endproperty
  a_done: assert property (p_done) else $error("done wrong");
  property p_src;
    config_from_mem_o |-> config_done_o && !marker_error_o &&
      !checksum_error_o;
  endproperty
  a_src: assert property (p_src) else $error("source wrong");
endmodule // tcf_format_config_sva

/* testbench/tcf_mem_model.sv */
// configuration memory model streaming its bytes into the block
`timescale 1ns/1ns
module tcf_mem_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic       absent_i,
  input  wire logic       bad_marker_i,
  input  wire logic       bad_sum_i,
  input  wire logic [7:0] first_i,
  input  wire logic [7:0] second_i,
  input  wire logic [7:0] drive_i,
  output logic            mem_byte_valid_o,
  output logic      [4:0] mem_byte_addr_o,
  output logic      [7:0] mem_byte_data_o,
  output logic            mem_read_done_o
);
  logic       run;
  logic       tg;
  logic [5:0] idx;
  logic [7:0] sum;
  logic [7:0] cur;
  // byte image; both fault flags together leave first word bit 4 raw
  always_comb begin
    case (idx)
      6'h00:   cur = bad_marker_i && !bad_sum_i ? 8'h55 : 8'hAA;
      6'h01: cur = first_i & {3'h7, &{bad_marker_i, bad_sum_i}, 4'hF};
      6'h02:   cur = second_i;
      6'h03:   cur = drive_i;
      6'h1F:   cur = sum + {7'h00, bad_sum_i && !bad_marker_i};
      default: cur = {2'h0, idx};
    endcase
  end
  // outputs; idle data toggles so no stale byte is seen
  assign mem_byte_valid_o = run && idx < 6'h20;
  assign mem_byte_addr_o  = idx[4:0];
  assign mem_byte_data_o  = mem_byte_valid_o ? cur : {8{tg}};
  assign mem_read_done_o  = run && idx == 6'h20;
  // one byte a cycle, done after the last one
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= 1'b0;
      tg  <= 1'b0;
      idx <= 6'h00;
      sum <= 8'h00;
    end else begin
      tg <= !tg;
      if (start_i && !run) begin
        run <= 1'b1;
        idx <= absent_i ? 6'h20 : 6'h00;
        sum <= 8'h00;
      end else if (run && idx == 6'h20) begin
        run <= 1'b0;
      end else if (run) begin
        idx <= idx + 6'h01;
        sum <= sum + cur;
      end
    end
  end
endmodule // tcf_mem_model

/* testbench/tcf_format_config_tb.sv */
// testbench for the format configuration block
`timescale 1ns/1ns
module tcf_format_config_tb;
  import tcf_pkg::*;
  logic        sys_clk_i, rst_n_i, pix_valid_i, start;
  logic        pixel_clock_input_i = 1'b0;
  logic        absent, bad_marker, bad_sum, mem_byte_valid_i;
  logic        mem_read_done_i, pix_valid_o, forwarded_clock_output_o;
  logic        config_done_o, config_from_mem_o, marker_error_o;
  logic        checksum_error_o, resolution_valid_o, dual_port_o;
  logic        video_invert_o, inversion_pattern_select_o, dither_en_o;
  logic        controller_mount_side_o, reserved_bit_error_o;
  logic        gate_oe_level_o, vblank_internal_o, input_8bit_o;
  logic        output_8bit_o, clock_passthru_o, clock_drive_valid_o;
  logic [1:0]  default_set_sel_i, gate_init_frames_o;
  logic [2:0]  resolution_o, k;
  logic [3:0]  clock_drive_half_x_o;
  logic [4:0]  mem_byte_addr_i;
  logic [5:0]  pll_min_x10_o;
  logic [6:0]  data_preemph_pct_o, clock_preemph_pct_o;
  logic [7:0]  first, second, drive, mem_byte_data_i, format_control_first_o;
  logic [7:0]  format_control_second_o, output_drive_levels_o;
  logic [23:0] pix_data_i, pix_data_o, w;
  int          fails = 0, tests_run = 0, cycles = 0;
  logic [23:0] defs [4] = '{{TCF_F1_DEF0, TCF_F2_DEF0, TCF_DL_DEF0},
    {TCF_F1_DEF1, TCF_F2_DEF1, TCF_DL_DEF1},
    {TCF_F1_DEF2, TCF_F2_DEF2, TCF_DL_DEF2},
    {TCF_F1_DEF3, TCF_F2_DEF3, TCF_DL_DEF3}};
  logic [63:0] pt [5] = '{{16'h0010, 24'hB7B7B7, 24'h2D2D2D},
    {16'h2010, 24'hB7B7B7, 24'h121212}, {16'h0020, 24'h2D2D2D, 24'hB6B6B6},
    {16'h0030, 24'hB7B7B7, 24'hB7B7B7}, {16'h0000, 24'hB7B7B7, 24'h373737}};

  tcf_format_config tcf_format_config_i (.sys_clk_i, .rst_n_i,
    .default_set_sel_i, .mem_byte_valid_i, .mem_byte_addr_i,
    .mem_byte_data_i, .mem_read_done_i, .pixel_clock_input_i,
    .forwarded_clock_output_o, .pix_valid_i, .pix_data_i, .pix_valid_o,
    .pix_data_o, .config_done_o, .config_from_mem_o, .marker_error_o,
    .checksum_error_o, .format_control_first_o, .format_control_second_o,
    .output_drive_levels_o, .resolution_o, .resolution_valid_o,
    .dual_port_o, .video_invert_o, .inversion_pattern_select_o,
    .controller_mount_side_o, .reserved_bit_error_o, .gate_oe_level_o,
    .gate_init_frames_o, .vblank_internal_o, .input_8bit_o, .output_8bit_o,
    .dither_en_o, .clock_passthru_o, .clock_drive_half_x_o,
    .clock_drive_valid_o, .pll_min_x10_o, .data_preemph_pct_o,
    .clock_preemph_pct_o);
  tcf_mem_model tcf_mem_model_i (.sys_clk_i, .rst_n_i, .start_i(start),
    .absent_i(absent), .bad_marker_i(bad_marker), .bad_sum_i(bad_sum),
    .first_i(first), .second_i(second), .drive_i(drive),
    .mem_byte_valid_o(mem_byte_valid_i), .mem_byte_addr_o(mem_byte_addr_i),
    .mem_byte_data_o(mem_byte_data_i), .mem_read_done_o(mem_read_done_i));

  // clocks and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = !sys_clk_i;
  end
  always @(posedge sys_clk_i) pixel_clock_input_i <= !pixel_clock_input_i;
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end

  task check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // reset with a strap value, then load the memory image
  task load(input logic [1:0] sel, input logic [23:0] wd,
            input logic [2:0] fl);
    int n;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    default_set_sel_i <= sel;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    {first, second, drive, absent, bad_marker, bad_sum} <= {wd, fl};
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
    for (n = 0; n < 60 && config_done_o !== 1'b1; n++) @(posedge sys_clk_i);
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  // every decoded field but reserved_bit_error_o against the intended words
  task chk_words(input logic [23:0] wd);
    logic [7:0] f1, f2, dl;
    {f1, f2, dl} = wd;
    check("words", {format_control_first_o, format_control_second_o,
      output_drive_levels_o}, wd);
    check("first", {resolution_o, resolution_valid_o, dual_port_o,
      video_invert_o, inversion_pattern_select_o, controller_mount_side_o},
      {f1[2:0], f1[2:0] != 3'h5 && f1[2:0] != 3'h7, f1[3], f1[5], f1[6],
      f1[7]});
    check("second", {gate_oe_level_o, gate_init_frames_o, vblank_internal_o,
      input_8bit_o, output_8bit_o, dither_en_o, clock_passthru_o},
      {f2[0], f2[2:1], f2[3], f2[4], f2[5], f2[6], !f2[7]});
    check("drive", {clock_drive_half_x_o, clock_drive_valid_o,
      pll_min_x10_o, data_preemph_pct_o, clock_preemph_pct_o},
      {{1'b0, dl[2:0]} + 4'h2, dl[2:0] != 3'h7, dl[3] ? 6'h1C : 6'h28,
      7'(dl[5:4]) * 7'h14, 7'(dl[7:6]) * 7'h14});
    check("fwd_clock", forwarded_clock_output_o,
      pixel_clock_input_i & !f2[7]);
  endtask
  task pix(input logic [23:0] din, exp);
    @(posedge sys_clk_i);
    pix_valid_i <= 1'b1;
    pix_data_i <= din;
    @(posedge sys_clk_i);
    pix_valid_i <= 1'b0;
    #1;
    check("pixel", {pix_valid_o, pix_data_o}, {1'b1, exp});
  endtask
  task print_verdict();
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // defaults, load faults, field table, pixel formats
  initial begin
    {rst_n_i, pix_valid_i, start, absent} = 4'h0;
    {bad_marker, bad_sum, default_set_sel_i} = 4'h0;
    {first, second, drive, pix_data_i} = 48'h0;
    for (int i = 0; i < 4; i++) begin
      load(2'(i), 24'h0, 3'h4);
      chk_words(defs[i]);
      check("from_mem", config_from_mem_o, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      load(2'h3, 24'h412233, j ? 3'h1 : 3'h2);
      chk_words(defs[3]);
      check("errors", {marker_error_o, checksum_error_o},
        j ? 2'h1 : 2'h2);
    end
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      w = {k, 1'b0, k[0], k, k[1:0], k, k, k[2:1], k[1:0], k[0], k};
      load(2'h1, w, 3'h0);
      chk_words(w);
      check("status", {config_done_o, config_from_mem_o, marker_error_o,
        checksum_error_o, reserved_bit_error_o}, 5'h18);
    end
    load(2'h0, 24'h100000, 3'h3);
    check("reserved", {config_from_mem_o, reserved_bit_error_o}, 2'h3);
    for (int j = 0; j < 5; j++) begin
      load(2'h0, {pt[j][63:48], 8'h00}, 3'h0);
      pix(pt[j][47:24], pt[j][23:0]);
    end
    load(2'h0, 24'h005000, 3'h0);
    for (int j = 0; j < 4; j++) pix(24'h010101, j == 3 ? 24'h010101 : 24'h0);
    print_verdict();
  end
endmodule // tcf_format_config_tb

bind tcf_format_config tcf_format_config_sva tcf_format_config_sva_i (
  .sys_clk_i, .rst_n_i, .pix_valid_i, .pix_valid_o, .mem_read_done_i,
  .config_done_o, .config_from_mem_o, .marker_error_o, .checksum_error_o,
  .gate_oe_level_o, .resolution_valid_o, .clock_passthru_o,
  .pixel_clock_input_i, .forwarded_clock_output_o, .clock_drive_valid_o,
  .format_control_first_o, .format_control_second_o, .output_drive_levels_o,
  .resolution_o, .clock_drive_half_x_o, .pll_min_x10_o, .data_preemph_pct_o,
  .clock_preemph_pct_o);
